// ==== core/emi_pkg.sv ====
// Shared constants and state type of the external data memory interface
package emi_pkg;
	// Special function register addresses
	localparam logic [7:0] PAGE_ADDR    = 8'ha2;
	localparam logic [7:0] CONFIG_ADDR  = 8'ha3;
	localparam logic [7:0] TIMING_ADDR  = 8'ha1;
	// Reset values
	localparam logic [7:0] PAGE_RESET   = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h03;
	localparam logic [7:0] TIMING_RESET = 8'hff;
	// Configuration field positions; top two bits unused
	localparam int          CFG_GROUP_BIT = 5;
	localparam int          CFG_MUX_BIT   = 4;
	localparam int          CFG_MODE_LSB  = 2;
	localparam int          CFG_ALE_LSB   = 0;
	localparam logic [7:0]  CFG_USED_MASK = 8'h3f;
	// Timing field positions
	localparam int          TM_SETUP_LSB  = 6;
	localparam int          TM_STROBE_LSB = 2;
	localparam int          TM_HOLD_LSB   = 0;
	// Memory modes
	localparam logic [1:0]  MODE_INTERNAL = 2'h0;
	localparam logic [1:0]  MODE_SPLIT    = 2'h1;
	localparam logic [1:0]  MODE_BANK     = 2'h2;
	localparam logic [1:0]  MODE_EXTERNAL = 2'h3;
	// On-chip space: 4k, twelve address bits
	localparam int          ONCHIP_BITS   = 12;
	// Fixed overhead of an off-chip move: one start cycle plus a tail
	localparam int          MOVE_OVERHEAD = 4;
	localparam logic [3:0]  TAIL_LOAD     = 4'h2;
	// Synchroniser depth for pin inputs
	localparam int          SYNC_STAGES   = 3;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_XRAM,
		ST_START,
		ST_ALEH,
		ST_ALEL,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_TAIL
	} emi_state_t;
endpackage : emi_pkg

// ==== core/xram_store.sv ====
// On-chip 4k byte data memory with registered read
`timescale 1ns/100ps
`default_nettype none
module xram_store (
	// Clock
	input  wire logic        clk,
	input  wire logic        ce,
	// Access
	input  wire logic        we,
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  wdata,
	output var  logic [7:0]  rdata
);
	logic [7:0] mem [0:(1 << emi_pkg::ONCHIP_BITS) - 1];

	// No reset on the array; contents are undefined after power-up
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			if (we)
				mem[addr] <= wdata;
			rdata <= mem[addr];
		end
	end
endmodule : xram_store
`default_nettype wire

// ==== core/pin_filter.sv ====
// Three-stage pin synchroniser that accepts a value once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_filter #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	// Pin and filtered value
	input  wire logic [WIDTH-1:0] pin,
	output var  logic [WIDTH-1:0] filtered
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_filtered;

	// Only stage two and three feed the comparison; stage one is metastable-prone
	always_comb
	begin
		next_filtered = filtered;
		if (stage2 == stage3)
			next_filtered = stage3;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			filtered <= '0;
		end
		else if (ce)
		begin
			stage1   <= pin;
			stage2   <= stage1;
			stage3   <= stage2;
			filtered <= next_filtered;
		end
	end
endmodule : pin_filter
`default_nettype wire

// ==== core/external_data_memory_interface.sv ====
// External data memory interface: move routing, on-chip store and off-chip bus cycles
//
// Contract
// - Eight-bit moves take high byte from page
// - Port group bit picks lower or upper pins
// - Multiplex bit shares or separates address/data
// - Mode 00: all moves on-chip, 4k wrap
// - Split 01: 8-bit off-chip leaves high undriven
// - Split 10: 8-bit off-chip drives page high
// - Split 16-bit: pointer decides, all lines driven
// - Mode 11: all off-chip, page ignored
// - Latch field sets high and low widths
// - Latch high with address, then data phase
// - Off-chip move lasts parameters plus four
// - Multiplexed adds at least two latch cycles
// - Setup and hold reset to maximum
// - Configuration resets 0x03, top bits zero
// - Setup field gives zero to three cycles
// - Strobe field gives one to sixteen cycles
// - Hold field gives zero to three cycles
// - Pins claimed only during off-chip move
`timescale 1ns/100ps
`default_nettype none
module external_data_memory_interface (
	// Clock, enable, reset
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        rstn,
	// Special function register port
	input  wire logic [7:0]  sfrAddr,
	input  wire logic        sfrWe,
	input  wire logic        sfrRe,
	input  wire logic [7:0]  sfrWdata,
	output var  logic [7:0]  sfrRdata,
	// Move requests from the core
	input  wire logic        movReq,
	input  wire logic        movWrite,
	input  wire logic        movWide,
	input  wire logic [15:0] dptr,
	input  wire logic [7:0]  regIndex,
	input  wire logic [7:0]  movWdata,
	output var  logic        movDone,
	output var  logic [7:0]  movRdata,
	output var  logic        busy,
	// Pins, index 0 lower port group, index 1 upper
	output var  logic [1:0]  busAle,
	output var  logic [1:0]  busRdN,
	output var  logic [1:0]  busWrN,
	output var  logic [1:0]  busCtlOeN,
	output var  logic [15:0] busAddrHi,
	output var  logic [1:0]  busAddrHiOeN,
	output var  logic [15:0] busAddrLo,
	output var  logic [1:0]  busAddrLoOeN,
	output var  logic [15:0] busData,
	output var  logic [1:0]  busDataOeN,
	input  wire logic [15:0] busDataIn
);
	// Register file
	logic [7:0] page;
	logic [7:0] cfg;
	logic [7:0] timing;
	logic [7:0] next_page;
	logic [7:0] next_cfg;
	logic [7:0] next_timing;
	logic [7:0] next_sfrRdata;

	// Move engine
	emi_pkg::emi_state_t state;
	emi_pkg::emi_state_t next_state;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic [15:0] moveAddr;
	logic [15:0] next_moveAddr;
	logic [7:0]  moveData;
	logic [7:0]  next_moveData;
	logic        moveWrite;
	logic        next_moveWrite;
	logic        moveHi;
	logic        next_moveHi;
	logic        moveGroup;
	logic        next_moveGroup;
	logic        moveMux;
	logic        next_moveMux;
	logic        next_movDone;
	logic [7:0]  next_movRdata;
	logic        next_busy;

	// Pin next values
	logic [1:0]  next_busAle;
	logic [1:0]  next_busRdN;
	logic [1:0]  next_busWrN;
	logic [1:0]  next_busCtlOeN;
	logic [15:0] next_busAddrHi;
	logic [1:0]  next_busAddrHiOeN;
	logic [15:0] next_busAddrLo;
	logic [1:0]  next_busAddrLoOeN;
	logic [15:0] next_busData;
	logic [1:0]  next_busDataOeN;

	// Decoded fields and routing
	logic [1:0]  mode;
	logic [1:0]  aleField;
	logic [1:0]  setupField;
	logic [3:0]  strobeField;
	logic [1:0]  holdField;
	logic [15:0] effAddr;
	logic        goOff;
	logic        take;
	logic        xramWe;
	logic [7:0]  xramQ;
	logic [15:0] dataFilt;
	logic        claimed;
	logic        addrPhase;
	logic [7:0]  rdCapture;
	logic [7:0]  next_rdCapture;

	assign mode        = cfg[emi_pkg::CFG_MODE_LSB +: 2];
	assign aleField    = cfg[emi_pkg::CFG_ALE_LSB +: 2];
	assign setupField  = timing[emi_pkg::TM_SETUP_LSB +: 2];
	assign strobeField = timing[emi_pkg::TM_STROBE_LSB +: 4];
	assign holdField   = timing[emi_pkg::TM_HOLD_LSB +: 2];

	// Route a move: effective address, then on-chip or off-chip
	always_comb
	begin
		effAddr = movWide ? dptr : {page, regIndex};
		case (mode)
			emi_pkg::MODE_INTERNAL: goOff = 1'b0;
			emi_pkg::MODE_EXTERNAL: goOff = 1'b1;
			default:                goOff = (effAddr[15:emi_pkg::ONCHIP_BITS] != 4'h0);
		endcase
	end

	assign take   = (state == emi_pkg::ST_IDLE) && movReq;
	assign xramWe = take && !goOff && movWrite;

	// On-chip store sees only the low twelve bits, so higher addresses wrap
	xram_store u_xram (
		.clk   (clk),
		.ce    (ce),
		.we    (xramWe),
		.addr  (effAddr[emi_pkg::ONCHIP_BITS-1:0]),
		.wdata (movWdata),
		.rdata (xramQ)
	);

	// Filtered copy of the data pins per group; it lags too far for read data
	pin_filter #(.WIDTH(8)) u_filt_lo (
		.clk      (clk),
		.rstn     (rstn),
		.ce       (ce),
		.pin      (busDataIn[7:0]),
		.filtered (dataFilt[7:0])
	);

	pin_filter #(.WIDTH(8)) u_filt_hi (
		.clk      (clk),
		.rstn     (rstn),
		.ce       (ce),
		.pin      (busDataIn[15:8]),
		.filtered (dataFilt[15:8])
	);

	// Register writes and reads; unmapped addresses read zero
	always_comb
	begin
		next_page     = page;
		next_cfg      = cfg;
		next_timing   = timing;
		next_sfrRdata = sfrRdata;
		if (sfrWe)
		begin
			case (sfrAddr)
				emi_pkg::PAGE_ADDR:   next_page   = sfrWdata;
				emi_pkg::CONFIG_ADDR: next_cfg    = sfrWdata & emi_pkg::CFG_USED_MASK;
				emi_pkg::TIMING_ADDR: next_timing = sfrWdata;
				default:              next_page   = page;
			endcase
		end
		if (sfrRe)
		begin
			case (sfrAddr)
				emi_pkg::PAGE_ADDR:   next_sfrRdata = page;
				emi_pkg::CONFIG_ADDR: next_sfrRdata = cfg;
				emi_pkg::TIMING_ADDR: next_sfrRdata = timing;
				default:              next_sfrRdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			page     <= emi_pkg::PAGE_RESET;
			cfg      <= emi_pkg::CONFIG_RESET;
			timing   <= emi_pkg::TIMING_RESET;
			sfrRdata <= 8'h00;
		end
		else if (ce)
		begin
			page     <= next_page;
			cfg      <= next_cfg;
			timing   <= next_timing;
			sfrRdata <= next_sfrRdata;
		end
	end

	// Move sequencer; timing fields are read live, so change them only while idle
	always_comb
	begin
		next_state     = state;
		next_cnt       = (cnt != 4'h0) ? cnt - 4'h1 : cnt;
		next_moveAddr  = moveAddr;
		next_moveData  = moveData;
		next_moveWrite = moveWrite;
		next_moveHi    = moveHi;
		next_moveGroup = moveGroup;
		next_moveMux   = moveMux;
		next_movDone   = 1'b0;
		next_movRdata  = movRdata;
		case (state)
			emi_pkg::ST_IDLE:
				if (movReq)
				begin
					next_moveAddr  = effAddr;
					next_moveData  = movWdata;
					next_moveWrite = movWrite;
					next_moveHi    = movWide || (mode == emi_pkg::MODE_BANK);
					next_moveGroup = cfg[emi_pkg::CFG_GROUP_BIT];
					next_moveMux   = !cfg[emi_pkg::CFG_MUX_BIT];
					next_cnt       = 4'h0;
					next_state     = goOff ? emi_pkg::ST_START : emi_pkg::ST_XRAM;
				end
			emi_pkg::ST_XRAM:
			begin
				next_movRdata = moveWrite ? movRdata : xramQ;
				next_movDone  = 1'b1;
				next_state    = emi_pkg::ST_IDLE;
			end
			emi_pkg::ST_START:
				if (moveMux)
				begin
					next_state = emi_pkg::ST_ALEH;
					next_cnt   = {2'b00, aleField};
				end
				else if (setupField != 2'h0)
				begin
					next_state = emi_pkg::ST_SETUP;
					next_cnt   = {2'b00, setupField} - 4'h1;
				end
				else
				begin
					next_state = emi_pkg::ST_STROBE;
					next_cnt   = strobeField;
				end
			emi_pkg::ST_ALEH:
				if (cnt == 4'h0)
				begin
					next_state = emi_pkg::ST_ALEL;
					next_cnt   = {2'b00, aleField};
				end
			emi_pkg::ST_ALEL:
				if (cnt == 4'h0 && setupField != 2'h0)
				begin
					next_state = emi_pkg::ST_SETUP;
					next_cnt   = {2'b00, setupField} - 4'h1;
				end
				else if (cnt == 4'h0)
				begin
					next_state = emi_pkg::ST_STROBE;
					next_cnt   = strobeField;
				end
			emi_pkg::ST_SETUP:
				if (cnt == 4'h0)
				begin
					next_state = emi_pkg::ST_STROBE;
					next_cnt   = strobeField;
				end
			emi_pkg::ST_STROBE:
				if (cnt == 4'h0 && holdField != 2'h0)
				begin
					next_state = emi_pkg::ST_HOLD;
					next_cnt   = {2'b00, holdField} - 4'h1;
				end
				else if (cnt == 4'h0)
				begin
					next_state = emi_pkg::ST_TAIL;
					next_cnt   = emi_pkg::TAIL_LOAD;
				end
			emi_pkg::ST_HOLD:
				if (cnt == 4'h0)
				begin
					next_state = emi_pkg::ST_TAIL;
					next_cnt   = emi_pkg::TAIL_LOAD;
				end
			emi_pkg::ST_TAIL:
				if (cnt == 4'h0)
				begin
					// Read data was taken at the close of the strobe
					if (!moveWrite)
						next_movRdata = rdCapture;
					next_movDone = 1'b1;
					next_state   = emi_pkg::ST_IDLE;
				end
			default:
				next_state = emi_pkg::ST_IDLE;
		endcase
		next_busy = (next_state != emi_pkg::ST_IDLE);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state     <= emi_pkg::ST_IDLE;
			cnt       <= 4'h0;
			moveAddr  <= 16'h0000;
			moveData  <= 8'h00;
			moveWrite <= 1'b0;
			moveHi    <= 1'b0;
			moveGroup <= 1'b0;
			moveMux   <= 1'b0;
			movDone   <= 1'b0;
			movRdata  <= 8'h00;
			busy      <= 1'b0;
		end
		else if (ce)
		begin
			state     <= next_state;
			cnt       <= next_cnt;
			moveAddr  <= next_moveAddr;
			moveData  <= next_moveData;
			moveWrite <= next_moveWrite;
			moveHi    <= next_moveHi;
			moveGroup <= next_moveGroup;
			moveMux   <= next_moveMux;
			movDone   <= next_movDone;
			movRdata  <= next_movRdata;
			busy      <= next_busy;
		end
	end

	// Read data sampled while the strobe pin is low; the last strobe cycle wins
	always_comb
	begin
		next_rdCapture = rdCapture;
		if (!busRdN[moveGroup])
			next_rdCapture = moveGroup ? busDataIn[15:8] : busDataIn[7:0];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdCapture <= 8'h00;
		else if (ce)
			rdCapture <= next_rdCapture;
	end

	// Pin drive follows the sequencer one cycle later
	assign claimed   = (state != emi_pkg::ST_IDLE) && (state != emi_pkg::ST_XRAM);
	assign addrPhase = (state == emi_pkg::ST_START) || (state == emi_pkg::ST_ALEH)
	                   || (state == emi_pkg::ST_ALEL);

	always_comb
	begin
		for (int g = 0; g < 2; g++)
		begin
			automatic logic sel = claimed && (moveGroup == g[0]);
			automatic logic strobe = sel && (state == emi_pkg::ST_STROBE);
			next_busAle[g]         = sel && moveMux && (state == emi_pkg::ST_ALEH);
			next_busRdN[g]         = !(strobe && !moveWrite);
			next_busWrN[g]         = !(strobe && moveWrite);
			next_busCtlOeN[g]      = !sel;
			next_busAddrHi[g*8 +: 8]  = moveAddr[15:8];
			next_busAddrHiOeN[g]   = !(sel && moveHi);
			next_busAddrLo[g*8 +: 8]  = moveAddr[7:0];
			next_busAddrLoOeN[g]   = !(sel && !moveMux);
			// Shared pins carry the low address first, then data
			next_busData[g*8 +: 8] = (moveMux && addrPhase) ? moveAddr[7:0] : moveData;
			next_busDataOeN[g]     = !(sel && ((moveMux && addrPhase) || moveWrite));
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busAle       <= 2'h0;
			busRdN       <= 2'h3;
			busWrN       <= 2'h3;
			busCtlOeN    <= 2'h3;
			busAddrHi    <= 16'h0000;
			busAddrHiOeN <= 2'h3;
			busAddrLo    <= 16'h0000;
			busAddrLoOeN <= 2'h3;
			busData      <= 16'h0000;
			busDataOeN   <= 2'h3;
		end
		else if (ce)
		begin
			busAle       <= next_busAle;
			busRdN       <= next_busRdN;
			busWrN       <= next_busWrN;
			busCtlOeN    <= next_busCtlOeN;
			busAddrHi    <= next_busAddrHi;
			busAddrHiOeN <= next_busAddrHiOeN;
			busAddrLo    <= next_busAddrLo;
			busAddrLoOeN <= next_busAddrLoOeN;
			busData      <= next_busData;
			busDataOeN   <= next_busDataOeN;
		end
	end

	// Checking helpers: cycles spent in the current off-chip move
	logic [5:0] moveLen;
	logic [5:0] expLen;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			moveLen <= 6'h00;
		else if (ce)
			moveLen <= (state == emi_pkg::ST_IDLE) ? 6'h01 : moveLen + 6'h01;
	end
	assign expLen = 6'({setupField} + {strobeField} + 6'h01 + {holdField} + emi_pkg::MOVE_OVERHEAD
	                + (moveMux ? 6'({aleField, 1'b0}) + 6'h02 : 6'h00));

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_move_length: assert property (ce && state == emi_pkg::ST_TAIL && cnt == 4'h0 |->
		moveLen == expLen) else $error("off-chip move length wrong");
	a_mux_minimum: assert property (ce && moveMux && state == emi_pkg::ST_TAIL && cnt == 4'h0 |->
		moveLen >= 6'h07) else $error("multiplexed move shorter than seven cycles");
	a_ale_during: assert property (ce && state == emi_pkg::ST_ALEH |=>
		busAle[moveGroup] && !busDataOeN[moveGroup] && busData[moveGroup*8 +: 8] == moveAddr[7:0])
		else $error("latch pulse without low address");
	a_onchip_quiet: assert property (state == emi_pkg::ST_XRAM |=>
		busCtlOeN == 2'h3 && busRdN == 2'h3 && busWrN == 2'h3 && busAle == 2'h0)
		else $error("on-chip move touched bus pins");
	a_idle_release: assert property (ce && state == emi_pkg::ST_IDLE && $past(state) == emi_pkg::ST_IDLE |=>
		busCtlOeN == 2'h3 && busAddrHiOeN == 2'h3 && busDataOeN == 2'h3)
		else $error("pins held while idle");
	a_internal_only: assert property (ce && take && mode == emi_pkg::MODE_INTERNAL |=>
		state == emi_pkg::ST_XRAM) else $error("internal mode went off-chip");
	a_external_only: assert property (ce && take && mode == emi_pkg::MODE_EXTERNAL |=>
		state == emi_pkg::ST_START && moveHi == $past(movWide)) else $error("external mode routing wrong");
	a_bank_high: assert property (ce && take && goOff && !movWide && mode == emi_pkg::MODE_BANK |=>
		moveHi && moveAddr[15:8] == $past(page)) else $error("bank high byte wrong");
	a_config_top: assert property (cfg[7:6] == 2'h0)
		else $error("unused configuration bits set");
	a_strobe_width: assert property (ce && $rose(state == emi_pkg::ST_STROBE) |->
		cnt == strobeField) else $error("strobe width load wrong");

	c_mux_read: cover property (ce && moveMux && !moveWrite && state == emi_pkg::ST_TAIL && cnt == 4'h0);
	c_plain_write: cover property (ce && !moveMux && moveWrite && state == emi_pkg::ST_TAIL && cnt == 4'h0);
	c_onchip: cover property (ce && state == emi_pkg::ST_XRAM);
	c_upper_group: cover property (ce && moveGroup && state == emi_pkg::ST_STROBE);
	c_read_settled: cover property (ce && !moveWrite && state == emi_pkg::ST_TAIL && cnt == 4'h0
		&& (moveGroup ? dataFilt[15:8] : dataFilt[7:0]) == rdCapture);
endmodule : external_data_memory_interface
`default_nettype wire

// ==== sim/sram_model.sv ====
// Off-chip asynchronous byte memory with its address latch, one per port group
`timescale 1ns/100ps
`default_nettype none
module sram_model (
	// Clock and wiring choice
	input  wire logic        clk,
	input  wire logic        mux,
	input  wire logic        slow,
	input  wire logic [7:0]  parkHi,
	// Pins
	input  wire logic        ale,
	input  wire logic        rdN,
	input  wire logic        wrN,
	input  wire logic        ctlOeN,
	input  wire logic [7:0]  addrHi,
	input  wire logic        addrHiOeN,
	input  wire logic [7:0]  addrLo,
	input  wire logic [7:0]  adPin,
	output var  logic [7:0]  dout,
	output var  logic [15:0] lastAddr,
	output var  logic        lastHiDriven
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  latchQ;
	logic [7:0]  noise = 8'h00;
	logic [15:0] addr;
	logic        answering = 1'b0;
	// Transparent while the enable is high, frozen from its fall
	always @*
		if (ale)
			latchQ = adPin;
	// Undriven high pins show the parked port value
	assign addr = {addrHiOeN ? parkHi : addrHi, mux ? latchQ : addrLo};
	// Strobe capture; the part drives its data only while the read strobe is low
	always @(posedge clk)
	begin
		noise <= noise + 8'h35;
		if (!wrN || !rdN)
		begin
			lastAddr     <= addr;
			lastHiDriven <= !addrHiOeN;
		end
		if (!wrN)
			mem[addr] <= adPin;
		answering <= !ctlOeN && !rdN;
	end
	// Slow part answers one cycle into the strobe; released lines toggle
	always @*
		if (!rdN && !slow)
			dout = mem[addr];
		else if (answering && !rdN)
			dout = mem[lastAddr];
		else
			dout = noise;
endmodule : sram_model
`default_nettype wire

// ==== sim/tb_external_data_memory_interface.sv ====
// Self-checking bench: registers, routing modes and off-chip cycle timing
`timescale 1ns/100ps
`default_nettype none
module tb_external_data_memory_interface;
	logic        clk = 1'b0, ce, rstn, sfrWe, sfrRe, movReq, movWrite, movWide;
	logic        movDone, busy, grp, mux, slow;
	logic [7:0]  sfrAddr, sfrWdata, sfrRdata, regIndex, movWdata, movRdata, parkHi;
	logic [15:0] dptr, busAddrHi, busAddrLo, busData, busDataIn;
	logic [1:0]  busAle, busRdN, busWrN, busCtlOeN, busAddrHiOeN, busAddrLoOeN, busDataOeN;
	logic [1:0]  hiDrv;
	logic [7:0]  dout [2];
	logic [15:0] lastAddr [2];
	int          n_errors = 0, checks = 0, nAle, nStb, nLo, nOwn, nOther;

	always #25 clk = ~clk;

	external_data_memory_interface DUT (.clk(clk), .ce(ce), .rstn(rstn), .sfrAddr(sfrAddr),
		.sfrWe(sfrWe), .sfrRe(sfrRe), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
		.movReq(movReq), .movWrite(movWrite), .movWide(movWide), .dptr(dptr),
		.regIndex(regIndex), .movWdata(movWdata), .movDone(movDone), .movRdata(movRdata),
		.busy(busy), .busAle(busAle), .busRdN(busRdN), .busWrN(busWrN),
		.busCtlOeN(busCtlOeN), .busAddrHi(busAddrHi), .busAddrHiOeN(busAddrHiOeN),
		.busAddrLo(busAddrLo), .busAddrLoOeN(busAddrLoOeN), .busData(busData),
		.busDataOeN(busDataOeN), .busDataIn(busDataIn));

	// One memory per group; pin level resolved from both drivers
	for (genvar g = 0; g < 2; g++)
	begin : gMem
		assign busDataIn[8*g +: 8] = busDataOeN[g] ? dout[g] : busData[8*g +: 8];
		sram_model mem (.clk(clk), .mux(mux), .slow(slow), .parkHi(parkHi),
			.ale(busAle[g]), .rdN(busRdN[g]), .wrN(busWrN[g]), .ctlOeN(busCtlOeN[g]),
			.addrHi(busAddrHi[8*g +: 8]), .addrHiOeN(busAddrHiOeN[g]),
			.addrLo(busAddrLo[8*g +: 8]), .adPin(busDataIn[8*g +: 8]), .dout(dout[g]),
			.lastAddr(lastAddr[g]), .lastHiDriven(hiDrv[g]));
	end

	// Pin activity per cycle, cleared by each move
	always @(posedge clk)
	begin
		nAle   += int'(busAle[grp]);
		nStb   += int'(!(busRdN[grp] && busWrN[grp]));
		nLo    += int'(!busAddrLoOeN[grp]);
		nOwn   += int'(!(&{busCtlOeN, busAddrHiOeN, busAddrLoOeN, busDataOeN}));
		nOther += int'(!busCtlOeN[!grp] || busAle[!grp]);
	end

	task automatic final_report;
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [15:0] exp, got);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h got %h", name, exp, got);
		end
	endtask : check

	task automatic sfr(input logic wr, input logic [7:0] a, d, output logic [7:0] r);
		@(negedge clk);
		{sfrAddr, sfrWdata, sfrWe, sfrRe} = {a, d, wr, !wr};
		@(negedge clk);
		{sfrWe, sfrRe} = 2'b00;
		r = sfrRdata;
	endtask : sfr

	// Cycles counted from the accepting edge to the edge that shows done
	task automatic move(input logic wr, wide, input logic [15:0] p, input logic [7:0] ri, wd,
		output logic [7:0] rd, output int cyc);
		@(negedge clk);
		{movWrite, movWide, dptr, regIndex, movWdata, movReq} = {wr, wide, p, ri, wd, 1'b1};
		{nAle, nStb, nLo, nOwn, nOther} = {5{32'sd0}};
		@(posedge clk);
		cyc = 0;
		@(negedge clk);
		movReq = 1'b0;
		while (movDone !== 1'b1)
		begin
			@(posedge clk);
			#1 cyc++;
			if (cyc > 200)
			begin
				n_errors++;
				final_report();
			end
		end
		rd = movRdata;
	endtask : move

	function automatic int expDur(input logic [7:0] tm, input logic [1:0] ale, input logic m);
		return int'(tm[7:6]) + int'(tm[5:2]) + 1 + int'(tm[1:0]) + 4 + (m ? 2 * (ale + 1) : 0);
	endfunction : expDur

	initial
	begin
		logic [7:0]  r, d, page, tm;
		logic [15:0] a, ea;
		logic [1:0]  mode, ale;
		logic        wide;
		int          c;
		void'($urandom(3428));
		{ce, rstn, sfrWe, sfrRe, movReq, movWrite, movWide, grp, mux, slow} = 10'h200;
		{sfrAddr, sfrWdata, regIndex, movWdata, parkHi, dptr} = 56'h0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		sfr(0, emi_pkg::TIMING_ADDR, 8'h00, r);
		check("timingReset", 8'hff, r);
		sfr(0, emi_pkg::PAGE_ADDR, 8'h00, r);
		check("pageReset", 8'h00, r);
		sfr(0, emi_pkg::CONFIG_ADDR, 8'h00, r);
		check("configReset", 8'h03, r);
		sfr(1, emi_pkg::CONFIG_ADDR, 8'hff, r);
		sfr(0, emi_pkg::CONFIG_ADDR, 8'h00, r);
		check("configTopBits", 8'h3f, r);
		sfr(0, 8'ha0, 8'h00, r);
		check("unmapped", 8'h00, r);
		// On-chip only, upper group: aliasing at 4k and a silent bus
		grp = 1'b1;
		sfr(1, emi_pkg::CONFIG_ADDR, 8'h20, r);
		move(1, 1, 16'h1005, 8'h00, 8'ha5, r, c);
		check("onchipCycles", 16'd1, 16'(c));
		sfr(1, emi_pkg::PAGE_ADDR, 8'h20, r);
		move(0, 0, 16'h0000, 8'h05, 8'h00, r, c);
		check("wrapData", 8'ha5, r);
		check("onchipPins", 16'd0, 16'(nOwn));
		// Split mode below 4k stays on-chip for both move widths
		grp = 1'b0;
		sfr(1, emi_pkg::CONFIG_ADDR, 8'h14, r);
		move(1, 1, 16'h0abc, 8'h00, 8'h3c, r, c);
		sfr(1, emi_pkg::PAGE_ADDR, 8'h0a, r);
		move(0, 0, 16'h0000, 8'hbc, 8'h00, r, c);
		check("splitOnchip", 8'h3c, r);
		check("splitPins", 16'd0, 16'(nOwn));
		// Off-chip write then read back under random settings; first three fix multiplexing and timing
		for (int i = 0; i < 40; i++)
		begin
			{grp, mux, mode, ale, tm} = {1'($urandom), 1'($urandom), 2'(1 + $urandom % 3),
				2'($urandom), 8'($urandom)};
			if (i == 0)
				{mux, tm} = {1'b0, 8'h00};
			if (i == 1)
				{mux, ale, tm} = {1'b1, 2'h0, 8'h00};
			if (i == 2)
				{mux, ale, tm} = {1'b1, 2'h3, 8'hff};
			slow = tm[5:2] >= 4'h3 && $urandom % 2 == 1;
			{parkHi, page, a, wide, d} = {8'($urandom), 8'($urandom), 16'($urandom),
				1'($urandom), 8'($urandom)};
			if (mode != 2'h3 && !wide && page < 8'h10)
				page[4] = 1'b1;
			if (mode != 2'h3 && wide && a < 16'h1000)
				a[12] = 1'b1;
			ea = wide ? a : (mode == 2'h2 ? {page, a[7:0]} : {parkHi, a[7:0]});
			sfr(1, emi_pkg::CONFIG_ADDR, {2'b00, grp, !mux, mode, ale}, r);
			sfr(1, emi_pkg::TIMING_ADDR, tm, r);
			sfr(1, emi_pkg::PAGE_ADDR, page, r);
			for (int w = 1; w >= 0; w--)
			begin
				move(1'(w), wide, a, a[7:0], d, r, c);
				check("moveCycles", 16'(expDur(tm, ale, mux)), 16'(c));
				check("strobeCycles", 16'(tm[5:2]) + 16'd1, 16'(nStb));
				check("aleCycles", mux ? 16'(ale) + 16'd1 : 16'd0, 16'(nAle));
				check("loAddrPins", 16'(!mux), 16'(nLo != 0));
				check("otherGroup", 16'd0, 16'(nOther));
				check("address", ea, lastAddr[grp]);
				check("hiDriven", 16'(wide || mode == 2'h2), 16'(hiDrv[grp]));
				repeat (2) @(negedge clk);
				check("released", 16'hff,
					{8'h0, busCtlOeN, busAddrHiOeN, busAddrLoOeN, busDataOeN});
			end
			check("readBack", 16'(d), 16'(r));
		end
		final_report();
	end
endmodule : tb_external_data_memory_interface
`default_nettype wire
